//--- hw/uep_regs.vh
/*
  Register map, field positions, reset values and timing counts of the
  generic-endpoint data pipe. Assumes a 100 MHz system clock and a
  register port of 8 address bits and 18 data bits.
*/
`ifndef UEP_REGS_VH
`define UEP_REGS_VH

// per-endpoint registers: address = {1'b0, ep_index[2:0], 1'b0, sel[2:0]}
`define UEP_SEL_DESC      3'h0
`define UEP_SEL_POLICY    3'h1
`define UEP_SEL_BASE      3'h2
`define UEP_SEL_SIZE      3'h3
`define UEP_SEL_RDOFF     3'h4
`define UEP_SEL_WROFF     3'h5
// global registers, address bit 7 set
`define UEP_ADDR_CFGVAL   8'h80
`define UEP_ADDR_STATUS   8'h81

// endpoint description fields
`define UEP_DESC_TYPE     1:0
`define UEP_DESC_DIR_IN   2
`define UEP_DESC_MPS      12:3
// stall policy fields
`define UEP_POL_NAKLIM    3:0

// reset values
`define UEP_RST_DESC      13'h0000
`define UEP_RST_NAKLIM    4'h0
`define UEP_RST_BASE      18'h00000
`define UEP_RST_OFF       16'h0000
`define UEP_RST_CFGVAL    16'h0000

// first and last generic endpoint numbers and the mask with all five init bits set
`define UEP_FIRST_EP      4'h4
`define UEP_LAST_EP       4'hb
`define UEP_INIT_ALL      5'h1f

// disconnect time before re-attach
`define UEP_CLK_NS        10
`define UEP_DISC_NS       10000
`define UEP_DISC_CYC      (`UEP_DISC_NS / `UEP_CLK_NS)

`endif

//--- hw/uep_ring_math.v
/*
  Ring pointer arithmetic for one buffer: the fill level between an
  advancing pointer and the opposite one, and the advanced pointer with
  wrap. Purely combinational; assumes size is nonzero and both pointers
  lie below it.
*/
`timescale 1ns/100ps
`default_nettype none

module uep_ring_math (
  // buffer geometry
  input  wire [15:0] size,
  // pointers
  input  wire [15:0] head,
  input  wire [15:0] tail,
  // results
  output wire [15:0] used,
  output wire [15:0] head_inc
);

  wire [15:0] head_p1;

  // difference taken modulo the buffer size
  assign used = (head >= tail) ? head - tail : head + size - tail; // R21
  assign head_p1 = head + 16'h0001;
  // pointer returns to zero at the buffer end
  assign head_inc = (head_p1 == size) ? 16'h0000 : head_p1; // R7

endmodule

`default_nettype wire

//--- hw/uep_bringup.v
/*
  Attach and re-enumeration sequencer. Holds the device as a
  configuration-only function after attach, and on a control register
  write drops the pull-up for a fixed time before re-attaching with the
  downloaded configuration. Assumes usb_attach is synchronous.
*/
`timescale 1ns/100ps
`default_nettype none
`include "uep_regs.vh"

module uep_bringup #(
  parameter DISC_CYC = `UEP_DISC_CYC
) (
  // clock and reset
  input  wire clk_sys,
  input  wire sys_rst,
  // bus state and requests
  input  wire usb_attach,
  input  wire usb_ctrl_wr,
  // link state
  output reg  pullup_en,
  output reg  config_only
);

  localparam [3:0] S_DETACH = 4'b0001;
  localparam [3:0] S_CONFIG = 4'b0010;
  localparam [3:0] S_DISC   = 4'b0100;
  localparam [3:0] S_RUN    = 4'b1000;

  reg [3:0]  state;
  reg [31:0] timer;

  always @(posedge clk_sys) begin
    if (sys_rst) begin
      state       <= S_DETACH;
      timer       <= 32'h0000_0000;
      pullup_en   <= 1'b0;
      config_only <= 1'b1;
    end else if (!usb_attach) begin
      state       <= S_DETACH;
      pullup_en   <= 1'b0;
      config_only <= 1'b1;
    end else begin
      case (state)
        S_DETACH: begin
          // only the control endpoint is offered at first
          state       <= S_CONFIG; // R16
          pullup_en   <= 1'b1;
          config_only <= 1'b1;
        end
        S_CONFIG: begin
          if (usb_ctrl_wr) begin
            state     <= S_DISC; // R17
            pullup_en <= 1'b0;
            timer     <= DISC_CYC - 1;
          end
        end
        S_DISC: begin
          if (timer == 32'h0000_0000) begin
            state       <= S_RUN; // R17
            pullup_en   <= 1'b1;
            config_only <= 1'b0;
          end else begin
            timer <= timer - 32'h0000_0001;
          end
        end
        S_RUN: begin
          // a further control write enumerates the new setup again
          if (usb_ctrl_wr) begin
            state       <= S_DISC;
            pullup_en   <= 1'b0;
            config_only <= 1'b1;
            timer       <= DISC_CYC - 1;
          end
        end
        default: begin
          state <= S_DETACH;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

//--- hw/uep_pipe.v
/*
  Hardware data pipe for the generic USB endpoints: ring buffers in DSP
  word memory, per-endpoint descriptors, ACK/NAK decisions, and a byte
  path for the control endpoint. Assumes the USB core delivers packets
  as tokens plus word streams, accepts IN words as presented, and the
  DSP memory returns read data one cycle after mem_rd is high.
*/
`timescale 1ns/100ps
`default_nettype none
`include "uep_regs.vh"

// Behaviour
// [R1] endpoints 4-11 served by hardware, no MCU
// [R2] per endpoint base, size, read, write offsets
// [R3] firmware keeps buffers inside 18-bit memory
// [R4] DSP memory moves whole 16-bit words only
// [R5] control endpoint may move single bytes
// [R6] OUT: pipe owns write; IN: read pointer
// [R7] pointers start at zero, wrap at end
// [R8] OUT fits: ACK then store write offset
// [R9] OUT collision: NAK, write offset unchanged
// [R10] OUT longer than max packet accepted if room
// [R11] firmware checks data, writes read offset
// [R12] IN full packet sent; read offset on ACK
// [R13] short IN: NAK count times, then send
// [R14] firmware checks room, writes write offset
// [R15] endpoint idle until all descriptors written
// [R16] attach first as configuration-only device
// [R17] control write: disconnect, then reconnect
// [R18] config value passed for host read-back
// [R19] type, direction, max packet from description
// [R20] NAK counter clears on every sent packet
// [R21] differences modulo size; collision is equality
module uep_pipe #(
  parameter NUM_EP   = 8,
  parameter DISC_CYC = `UEP_DISC_CYC
) (
  // clock and reset
  input  wire        clk_sys,
  input  wire        sys_rst,
  // DSP register port
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire [7:0]  reg_addr,
  input  wire [17:0] reg_wdata,
  output reg  [17:0] reg_rdata,
  // token from the USB core
  input  wire        tok_valid,
  input  wire [3:0]  tok_ep,
  input  wire        tok_in,
  // OUT word stream
  input  wire        out_valid,
  input  wire [15:0] out_data,
  input  wire        out_last,
  // IN handshake from the host
  input  wire        in_ack,
  input  wire        in_abort,
  // answers to the USB core
  output reg         hs_ack,
  output reg         hs_nak,
  output reg         in_valid,
  output reg  [15:0] in_data,
  output reg         in_last,
  // DSP memory port
  output reg         mem_wr,
  output reg         mem_rd,
  output reg  [1:0]  mem_be,
  output reg  [17:0] mem_addr,
  output reg  [15:0] mem_wdata,
  input  wire [15:0] mem_rdata,
  // control endpoint byte path
  input  wire        ep0_req,
  input  wire        ep0_wr,
  input  wire [17:0] ep0_addr,
  input  wire        ep0_hi,
  input  wire [7:0]  ep0_wdata,
  output reg         ep0_done,
  output reg  [7:0]  ep0_rdata,
  // bring-up
  input  wire        usb_attach,
  input  wire        usb_ctrl_wr,
  output wire        pullup_en,
  output wire        config_only,
  output reg  [15:0] cfg_value
);

  localparam [7:0] S_IDLE = 8'b0000_0001;
  localparam [7:0] S_OUT  = 8'b0000_0010;
  localparam [7:0] S_IRD  = 8'b0000_0100;
  localparam [7:0] S_IWT  = 8'b0000_1000;
  localparam [7:0] S_IDAT = 8'b0001_0000;
  localparam [7:0] S_IHS  = 8'b0010_0000;
  localparam [7:0] S_E0A  = 8'b0100_0000;
  localparam [7:0] S_E0B  = 8'b1000_0000;

  function ep_reg_hit;
    input [7:0] addr;
    input [2:0] idx;
    input [2:0] sel;
    begin
      ep_reg_hit = !addr[7] && !addr[3] && addr[6:4] == idx &&
                   addr[2:0] == sel;
    end
  endfunction

  // per-endpoint storage
  reg [12:0] desc_r   [0:NUM_EP-1];
  reg [3:0]  naklim_r [0:NUM_EP-1];
  reg [17:0] base_r   [0:NUM_EP-1];
  reg [15:0] size_r   [0:NUM_EP-1];
  reg [15:0] rdoff_r  [0:NUM_EP-1];
  reg [15:0] wroff_r  [0:NUM_EP-1];
  reg [3:0]  nakcnt_r [0:NUM_EP-1];
  reg [4:0]  init_r   [0:NUM_EP-1];

  reg [7:0]  state;
  reg [2:0]  cur_idx;
  reg [17:0] cur_base;
  reg [15:0] cur_size;
  reg [15:0] cur_ptr;
  reg [15:0] cur_opp;
  reg [9:0]  cur_cnt;
  reg [9:0]  cur_len;
  reg        collided;
  reg        e0_hi;
  // pipe-side pointer and counter updates, one endpoint per cycle
  reg        upd_wr;
  reg        upd_rd;
  reg        nak_inc;
  reg        nak_clr;
  reg [15:0] upd_val;

  wire [3:0]  tsub     = tok_ep - `UEP_FIRST_EP;
  wire [2:0]  tidx     = tsub[2:0];
  wire        tok_gen  = tok_ep >= `UEP_FIRST_EP && tok_ep <= `UEP_LAST_EP;
  wire [12:0] tdesc    = desc_r[tidx];
  wire [9:0]  tmps     = tdesc[`UEP_DESC_MPS];
  wire [9:0]  tmpsw    = {1'b0, tmps[9:1]};
  wire        tok_ok   = tok_gen && init_r[tidx] == `UEP_INIT_ALL &&
                         !config_only && tok_in == tdesc[`UEP_DESC_DIR_IN];
  wire        idle     = state == S_IDLE;
  wire [15:0] sel_size = idle ? size_r[tidx] : cur_size;
  wire [15:0] sel_head = idle ? wroff_r[tidx] : cur_ptr;
  wire [15:0] sel_tail = idle ? rdoff_r[tidx] : cur_opp;
  wire [15:0] used;
  wire [15:0] head_inc;
  wire        out_take = !collided && head_inc != cur_opp;

  uep_ring_math u_ring (
    .size     (sel_size),
    .head     (sel_head),
    .tail     (sel_tail),
    .used     (used),
    .head_inc (head_inc)
  );

  uep_bringup #(
    .DISC_CYC (DISC_CYC)
  ) u_bringup (
    .clk_sys     (clk_sys),
    .sys_rst     (sys_rst),
    .usb_attach  (usb_attach),
    .usb_ctrl_wr (usb_ctrl_wr),
    .pullup_en   (pullup_en),
    .config_only (config_only)
  );

  genvar gi;
  generate
    for (gi = 0; gi < NUM_EP; gi = gi + 1) begin : g_ep
      localparam [2:0] IDX = gi;
      wire mine = cur_idx == gi;
      always @(posedge clk_sys) begin
        if (sys_rst) begin
          desc_r[gi]   <= `UEP_RST_DESC;
          naklim_r[gi] <= `UEP_RST_NAKLIM;
          base_r[gi]   <= `UEP_RST_BASE;
          size_r[gi]   <= `UEP_RST_OFF;
          rdoff_r[gi]  <= `UEP_RST_OFF; // R7
          wroff_r[gi]  <= `UEP_RST_OFF; // R7
          nakcnt_r[gi] <= 4'h0;
          init_r[gi]   <= 5'h00;
        end else begin
          if (reg_wr) begin
            if (ep_reg_hit(reg_addr, IDX, `UEP_SEL_DESC)) begin
              desc_r[gi] <= reg_wdata[12:0]; // R19
              init_r[gi][0] <= 1'b1; // R15
            end
            if (ep_reg_hit(reg_addr, IDX, `UEP_SEL_POLICY))
              naklim_r[gi] <= reg_wdata[`UEP_POL_NAKLIM]; // R13
            if (ep_reg_hit(reg_addr, IDX, `UEP_SEL_BASE)) begin
              base_r[gi] <= reg_wdata; // R2
              init_r[gi][1] <= 1'b1; // R15
            end
            if (ep_reg_hit(reg_addr, IDX, `UEP_SEL_SIZE)) begin
              size_r[gi] <= reg_wdata[15:0]; // R2
              init_r[gi][2] <= 1'b1; // R15
            end
            if (ep_reg_hit(reg_addr, IDX, `UEP_SEL_RDOFF)) begin
              rdoff_r[gi] <= reg_wdata[15:0]; // R11
              init_r[gi][3] <= 1'b1; // R15
            end
            if (ep_reg_hit(reg_addr, IDX, `UEP_SEL_WROFF)) begin
              wroff_r[gi] <= reg_wdata[15:0]; // R14
              init_r[gi][4] <= 1'b1; // R15
            end
          end
          // pipe update lands after the DSP write so it wins a tie
          if (upd_wr && mine)
            wroff_r[gi] <= upd_val; // R6
          if (upd_rd && mine)
            rdoff_r[gi] <= upd_val; // R6
          if (nak_clr && mine)
            nakcnt_r[gi] <= 4'h0; // R20
          else if (nak_inc && mine)
            nakcnt_r[gi] <= nakcnt_r[gi] + 4'h1;
        end
      end
    end
  endgenerate

  // pipe engine; endpoints 4-11 never involve the MCU
  always @(posedge clk_sys) begin // R1
    if (sys_rst) begin
      state     <= S_IDLE;
      cur_idx   <= 3'h0;
      cur_base  <= 18'h00000;
      cur_size  <= 16'h0000;
      cur_ptr   <= 16'h0000;
      cur_opp   <= 16'h0000;
      cur_cnt   <= 10'h000;
      cur_len   <= 10'h000;
      collided  <= 1'b0;
      e0_hi     <= 1'b0;
      upd_wr    <= 1'b0;
      upd_rd    <= 1'b0;
      nak_inc   <= 1'b0;
      nak_clr   <= 1'b0;
      upd_val   <= 16'h0000;
      hs_ack    <= 1'b0;
      hs_nak    <= 1'b0;
      in_valid  <= 1'b0;
      in_data   <= 16'h0000;
      in_last   <= 1'b0;
      mem_wr    <= 1'b0;
      mem_rd    <= 1'b0;
      mem_be    <= 2'b00;
      mem_addr  <= 18'h00000;
      mem_wdata <= 16'h0000;
      ep0_done  <= 1'b0;
      ep0_rdata <= 8'h00;
    end else begin
      upd_wr   <= 1'b0;
      upd_rd   <= 1'b0;
      nak_inc  <= 1'b0;
      nak_clr  <= 1'b0;
      hs_ack   <= 1'b0;
      hs_nak   <= 1'b0;
      in_valid <= 1'b0;
      in_last  <= 1'b0;
      mem_wr   <= 1'b0;
      mem_rd   <= 1'b0;
      ep0_done <= 1'b0;
      case (state)
        S_IDLE: begin
          cur_cnt <= 10'h000;
          if (tok_valid) begin
            cur_idx  <= tidx;
            cur_base <= base_r[tidx];
            cur_size <= size_r[tidx];
            if (!tok_in) begin
              cur_ptr  <= wroff_r[tidx];
              cur_opp  <= rdoff_r[tidx];
              // unusable endpoint: swallow the data and NAK it
              collided <= !tok_ok; // R15
              state    <= S_OUT;
            end else if (!tok_ok) begin
              hs_nak <= 1'b1; // R15
            end else begin
              cur_ptr <= rdoff_r[tidx];
              if (used >= {6'h00, tmpsw}) begin
                cur_len <= tmpsw; // R12
                nak_clr <= 1'b1; // R20
                state   <= S_IRD;
              end else if (nakcnt_r[tidx] < naklim_r[tidx]) begin
                hs_nak  <= 1'b1; // R13
                nak_inc <= 1'b1;
              end else begin
                cur_len <= used[9:0]; // R13
                nak_clr <= 1'b1; // R20
                if (used == 16'h0000) begin
                  in_last <= 1'b1;
                  state   <= S_IHS;
                end else begin
                  state <= S_IRD;
                end
              end
            end
          end else if (ep0_req) begin
            // control endpoint may touch a single byte lane
            mem_wr    <= ep0_wr; // R5
            mem_rd    <= !ep0_wr;
            mem_be    <= ep0_hi ? 2'b10 : 2'b01;
            mem_addr  <= ep0_addr;
            mem_wdata <= {ep0_wdata, ep0_wdata};
            e0_hi     <= ep0_hi;
            state     <= S_E0A;
          end
        end
        S_OUT: begin
          if (out_valid) begin
            if (out_take) begin
              mem_wr    <= 1'b1;
              mem_be    <= 2'b11; // R4
              mem_addr  <= cur_base + {2'b00, cur_ptr};
              mem_wdata <= out_data;
              // no packet size limit, only room in the ring
              cur_ptr   <= head_inc; // R10
            end else begin
              collided <= 1'b1; // R21
            end
            if (out_last) begin
              state <= S_IDLE;
              if (out_take) begin
                hs_ack  <= 1'b1; // R8
                upd_wr  <= 1'b1; // R8
                upd_val <= head_inc;
              end else begin
                hs_nak <= 1'b1; // R9
              end
            end
          end
        end
        S_IRD: begin
          mem_rd   <= 1'b1;
          mem_be   <= 2'b11; // R4
          mem_addr <= cur_base + {2'b00, cur_ptr};
          cur_ptr  <= head_inc;
          state    <= S_IWT;
        end
        S_IWT: begin
          state <= S_IDAT;
        end
        S_IDAT: begin
          in_valid <= 1'b1;
          in_data  <= mem_rdata;
          cur_cnt  <= cur_cnt + 10'h001;
          if (cur_cnt + 10'h001 == cur_len) begin
            in_last <= 1'b1;
            state   <= S_IHS;
          end else begin
            state <= S_IRD;
          end
        end
        S_IHS: begin
          // stored read offset moves only once the host has the data
          if (in_ack) begin
            upd_rd  <= 1'b1; // R12
            upd_val <= cur_ptr;
            state   <= S_IDLE;
          end else if (in_abort) begin
            state <= S_IDLE;
          end
        end
        S_E0A: begin
          state <= S_E0B;
        end
        S_E0B: begin
          ep0_done  <= 1'b1;
          ep0_rdata <= e0_hi ? mem_rdata[15:8] : mem_rdata[7:0]; // R5
          state     <= S_IDLE;
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  // DSP side register read-back and configuration value
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      reg_rdata <= 18'h00000;
      cfg_value <= `UEP_RST_CFGVAL;
    end else begin
      if (reg_wr && reg_addr == `UEP_ADDR_CFGVAL)
        cfg_value <= reg_wdata[15:0]; // R18
      if (reg_rd) begin
        reg_rdata <= 18'h00000;
        if (reg_addr == `UEP_ADDR_CFGVAL)
          reg_rdata <= {2'b00, cfg_value};
        else if (reg_addr == `UEP_ADDR_STATUS)
          reg_rdata <= {15'h0000, !idle, pullup_en, config_only};
        else if (!reg_addr[7] && !reg_addr[3]) begin
          case (reg_addr[2:0])
            `UEP_SEL_DESC:   reg_rdata <= {5'h00, desc_r[reg_addr[6:4]]};
            `UEP_SEL_POLICY: reg_rdata <= {10'h000, nakcnt_r[reg_addr[6:4]],
                                           naklim_r[reg_addr[6:4]]};
            `UEP_SEL_BASE:   reg_rdata <= base_r[reg_addr[6:4]];
            `UEP_SEL_SIZE:   reg_rdata <= {2'b00, size_r[reg_addr[6:4]]};
            `UEP_SEL_RDOFF:  reg_rdata <= {2'b00, rdoff_r[reg_addr[6:4]]};
            `UEP_SEL_WROFF:  reg_rdata <= {2'b00, wroff_r[reg_addr[6:4]]};
            default:         reg_rdata <= 18'h00000;
          endcase
        end
      end
    end
  end

endmodule

`default_nettype wire

//--- testbench/uep_dsp_mem.sv
/*
  DSP word memory model facing the pipe's memory port.
  Assumes addresses below 1024 words and one-cycle read latency.
*/
`timescale 1ns/100ps
`default_nettype none

module uep_dsp_mem (
  // clock
  input  wire logic        clk_sys,
  // memory port
  input  wire logic        mem_wr,
  input  wire logic        mem_rd,
  input  wire logic [1:0]  mem_be,
  input  wire logic [17:0] mem_addr,
  input  wire logic [15:0] mem_wdata,
  output var  logic [15:0] mem_rdata
);
  logic [15:0] mem [0:1023];

  initial begin
    mem_rdata = 16'h0000;
    for (int i = 0; i < 1024; i++) begin
      mem[i] = 16'h0000;
    end
  end

  always @(posedge clk_sys) begin
    if (mem_wr && mem_be[0]) mem[mem_addr[9:0]][7:0] <= mem_wdata[7:0];
    if (mem_wr && mem_be[1]) mem[mem_addr[9:0]][15:8] <= mem_wdata[15:8];
    // stale data toggles so a late sample cannot pass
    if (mem_rd) mem_rdata <= mem[mem_addr[9:0]];
    else mem_rdata <= ~mem_rdata;
  end
endmodule
`default_nettype wire

//--- testbench/uep_pipe_monitor.sv
/*
  Concurrent checks on the pipe's ports.
  Assumes attach stays high once the configuration is downloaded.
*/
`timescale 1ns/100ps
`default_nettype none

module uep_pipe_monitor #(
  parameter DISC_CYC = 4
) (
  // clock and reset
  input wire logic       clk_sys,
  input wire logic       sys_rst,
  // requests
  input wire logic       tok_valid,
  input wire logic       tok_in,
  input wire logic       out_valid,
  input wire logic       out_last,
  input wire logic       ep0_req,
  input wire logic       usb_attach,
  input wire logic       usb_ctrl_wr,
  // answers
  input wire logic       hs_ack,
  input wire logic       hs_nak,
  input wire logic       in_valid,
  input wire logic       in_last,
  input wire logic       mem_wr,
  input wire logic       mem_rd,
  input wire logic [1:0] mem_be,
  input wire logic       ep0_done,
  input wire logic       pullup_en,
  input wire logic       config_only
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  logic        seen_ctrl;
  logic [15:0] low_cnt;

  always @(posedge clk_sys) begin
    if (sys_rst || !usb_attach) seen_ctrl <= 1'b0;
    else if (usb_ctrl_wr) seen_ctrl <= 1'b1;
    if (sys_rst || pullup_en) low_cnt <= 16'h0000;
    else low_cnt <= low_cnt + 16'h0001;
  end

  sequence s_out_end;
    out_valid && out_last;
  endsequence
  sequence s_ep0_mem;
    (mem_wr || mem_rd) ##2 ep0_done;
  endsequence

  out_answer_a: assert property (s_out_end |=> hs_ack != hs_nak)
    else $error("out packet answer missing or doubled");
  ack_cause_a: assert property (hs_ack |-> $past(out_valid && out_last))
    else $error("ack without end of out packet");
  nak_cause_a: assert property (hs_nak |->
    $past(tok_valid && tok_in) || $past(out_valid && out_last))
    else $error("nak outside an answer slot");
  word_only_a: assert property (mem_wr && mem_be != 2'h3 |->
    $past(ep0_req)) else $error("partial word write off control path");
  ep0_path_a: assert property (ep0_req && !tok_valid |=> s_ep0_mem)
    else $error("control byte access timing wrong");
  in_answer_a: assert property (tok_valid && tok_in |->
    ##[1:5] (hs_nak || in_valid || in_last))
    else $error("in token not answered");
  in_pace_a: assert property (in_valid && !in_last |-> ##3 in_valid)
    else $error("in words not three cycles apart");
  cfg_only_a: assert property (usb_attach && !seen_ctrl |-> config_only)
    else $error("left configuration-only state early");
  disc_a: assert property (usb_ctrl_wr && pullup_en |-> ##[1:2] !pullup_en)
    else $error("no disconnect after control write");
  reconn_a: assert property ($rose(pullup_en) && seen_ctrl |->
    !config_only && low_cnt >= DISC_CYC - 1)
    else $error("reconnect too soon or still configuration-only");
endmodule

bind uep_pipe uep_pipe_monitor #(.DISC_CYC(DISC_CYC)) u_mon (.*);
`default_nettype wire

//--- testbench/test_uep_pipe.sv
/*
  Self-checking bench for the generic-endpoint pipe with a word memory.
  Assumes the register map of uep_regs.vh.
*/
`timescale 1ns/100ps
`default_nettype none
`include "uep_regs.vh"

module test_uep_pipe;
  localparam int DC = 4;
  logic        clk_sys, sys_rst, reg_wr, reg_rd, tok_valid, tok_in;
  logic        out_valid, out_last, in_ack, in_abort, hs_ack, hs_nak;
  logic        in_valid, in_last, mem_wr, mem_rd, ep0_req, ep0_wr, ep0_hi;
  logic        ep0_done, usb_attach, usb_ctrl_wr, pullup_en, config_only;
  logic [1:0]  mem_be;
  logic [3:0]  tok_ep;
  logic [7:0]  reg_addr, ep0_wdata, ep0_rdata;
  logic [15:0] out_data, in_data, mem_wdata, mem_rdata, cfg_value;
  logic [17:0] reg_wdata, reg_rdata, mem_addr, ep0_addr;
  logic [15:0] sent[$], rx[$];
  int          n_mismatch = 0, comparisons = 0, cyc = 0;

  uep_pipe #(.DISC_CYC(DC)) dut (.*);
  uep_dsp_mem u_mem (.clk_sys(clk_sys), .mem_wr(mem_wr), .mem_rd(mem_rd),
    .mem_be(mem_be), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata));

  initial begin
    clk_sys = 0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic test_done();
    $display("comparisons=%0d n_mismatch=%0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // a hang counts as a mismatch
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      test_done();
    end
  end

  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic [7:0] ra(input int ep, input int s);
    return {1'b0, 3'(ep - 4), 1'b0, 3'(s)};
  endfunction

  task automatic wr(input logic [7:0] a, input logic [17:0] d);
    reg_wr = 1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk_sys) reg_wr = 0;
    @(negedge clk_sys);
  endtask

  task automatic rd(input logic [7:0] a, output logic [17:0] d);
    reg_rd = 1;
    reg_addr = a;
    @(negedge clk_sys) reg_rd = 0;
    d = reg_rdata;
    @(negedge clk_sys);
  endtask

  task automatic cfg(input int ep, d, mps, lim, b, s);
    wr(ra(ep, 0), {5'h0, 10'(mps), 1'(d), 2'h2});
    wr(ra(ep, 1), 18'(lim));
    wr(ra(ep, 2), 18'(b));
    wr(ra(ep, 3), 18'(s));
    wr(ra(ep, 4), 18'h0);
    wr(ra(ep, 5), 18'h0);
  endtask

  task automatic token(input int ep, input logic dir_in);
    tok_valid = 1;
    tok_in = dir_in;
    tok_ep = 4'(ep);
    @(negedge clk_sys) tok_valid = 0;
  endtask

  task automatic out_pkt(input int ep, input int n, output logic r);
    int k;
    sent = {};
    token(ep, 0);
    for (int i = 0; i < n; i++) begin
      out_valid = 1;
      out_data = 16'($urandom);
      out_last = (i == n - 1);
      sent.push_back(out_data);
      @(negedge clk_sys);
    end
    out_valid = 0;
    out_last = 0;
    for (k = 0; k < 8 && !hs_ack && !hs_nak; k++) @(negedge clk_sys);
    r = (k < 8) ? hs_ack : 1'bx;
    @(negedge clk_sys);
  endtask

  task automatic in_pkt(input int ep, input logic a, output logic nak);
    int k;
    rx = {};
    token(ep, 1);
    for (k = 0; k < 200 && !in_last && !hs_nak; k++) begin
      if (in_valid) rx.push_back(in_data);
      @(negedge clk_sys);
    end
    if (in_valid) rx.push_back(in_data);
    nak = (k < 200) ? hs_nak : 1'bx;
    if (!nak) begin
      in_ack = a;
      in_abort = !a;
      @(negedge clk_sys);
      in_ack = 0;
      in_abort = 0;
    end
    @(negedge clk_sys);
  endtask

  task automatic ep0(input logic w, input logic h, input logic [7:0] d);
    ep0_req = 1;
    ep0_wr = w;
    ep0_addr = 18'h00384;
    ep0_hi = h;
    ep0_wdata = d;
    @(negedge clk_sys) ep0_req = 0;
    for (int k = 0; k < 8 && !ep0_done; k++) @(negedge clk_sys);
    @(negedge clk_sys);
  endtask

  initial begin
    logic [17:0] v;
    logic        r, ack;
    int          base, sz, rp, wp, fr, n, cnt;
    {reg_wr, reg_rd, tok_valid, tok_in, out_valid, out_last} = '0;
    {in_ack, in_abort, ep0_req, ep0_wr, ep0_hi, usb_ctrl_wr} = '0;
    {reg_addr, reg_wdata, tok_ep, out_data, ep0_addr, ep0_wdata} = '0;
    sys_rst = 1;
    usb_attach = 1;
    void'($urandom(32'h294a));
    repeat (16) @(negedge clk_sys);
    sys_rst = 0;
    repeat (3) @(negedge clk_sys);
    chk({pullup_en, config_only}, 18'h3);
    for (int s = 2; s < 6; s++) begin
      rd(ra(4, s), v);
      chk(v, 18'h0);
    end
    rd(8'h0e, v);
    chk(v, 18'h0);
    n = $urandom;
    wr(`UEP_ADDR_CFGVAL, 18'(n[15:0]));
    chk(cfg_value, n[15:0]);
    rd(`UEP_ADDR_CFGVAL, v);
    chk(v, n[15:0]);
    base = $urandom_range(255);
    sz = 16;
    cfg(5, 0, 8, 0, base, sz);
    out_pkt(5, 2, r);
    chk(r, 18'h0);
    usb_ctrl_wr = 1;
    @(negedge clk_sys) usb_ctrl_wr = 0;
    @(negedge clk_sys);
    chk(pullup_en, 18'h0);
    repeat (DC + 4) @(negedge clk_sys);
    chk({pullup_en, config_only}, 18'h2);
    out_pkt(2, 2, r);
    chk(r, 18'h0);
    out_pkt(6, 1, r);
    chk(r, 18'h0);
    in_pkt(5, 1, r);
    chk(r, 18'h1);
    rp = 0;
    wp = 0;
    repeat (24) begin
      n = $urandom_range(8, 1);
      fr = (rp - wp - 1 + sz) % sz;
      out_pkt(5, n, r);
      chk(r, 18'(n <= fr));
      for (int i = 0; i < n && n <= fr; i++)
        chk(u_mem.mem[base + (wp + i) % sz], sent[i]);
      if (n <= fr) wp = (wp + n) % sz;
      rd(ra(5, 5), v);
      chk(v, 18'(wp));
      rp = (rp + $urandom_range((wp - rp + sz) % sz)) % sz;
      wr(ra(5, 4), 18'(rp));
    end
    base = 512 + $urandom_range(255);
    cfg(4, 1, 8, 2, base, sz);
    rp = 0;
    wp = 0;
    cnt = 0;
    repeat (30) begin
      n = $urandom_range((rp - wp - 1 + sz) % sz) % 3;
      for (int i = 0; i < n; i++)
        u_mem.mem[base + (wp + i) % sz] = 16'($urandom);
      wp = (wp + n) % sz;
      wr(ra(4, 5), 18'(wp));
      ack = 1'($urandom);
      in_pkt(4, ack, r);
      fr = (wp - rp + sz) % sz;
      n = fr < 4 ? fr : 4;
      if (fr < 4 && cnt < 2) begin
        chk(r, 18'h1);
        cnt++;
      end else begin
        chk(r, 18'h0);
        chk(18'(rx.size()), 18'(n));
        for (int i = 0; i < n && i < rx.size(); i++)
          chk(rx[i], u_mem.mem[base + (rp + i) % sz]);
        cnt = 0;
        if (ack) rp = (rp + n) % sz;
      end
      rd(ra(4, 4), v);
      chk(v, 18'(rp));
    end
    usb_attach = 0;
    @(negedge clk_sys) chk(pullup_en, 18'h0);
    usb_attach = 1;
    @(negedge clk_sys) chk({pullup_en, config_only}, 18'h3);
    u_mem.mem[900] = 16'h1234;
    ep0(1, 1, 8'h5a);
    chk(u_mem.mem[900], 18'h05a34);
    ep0(0, 0, 8'h00);
    chk(ep0_rdata, 18'h34);
    test_done();
  end
endmodule
`default_nettype wire
